// [hub_cmd_decoder.sv]
// What this block does
// - Family 0x14 index 0x00 sends every byte after the two command bytes into the input FIFO and answers no data.
// - Family 0x40 takes an address byte then a value byte and writes the value to that sensor register.
// - The index byte 0x00 to 0x04 picks one of five sensors, 0x04 being the accelerometer.
// - Family 0x41 takes an address byte and answers the current value of that sensor register.
// - Family 0x42 takes no bytes and answers the word size in bytes then the register count.
// - Family 0x43 takes no bytes and answers address and value pairs from register 0 to the last.
// - An accelerometer sample is 6 bytes, three 16-bit two's complement axes with LSB of 0.001 g.
`timescale 1ns/10ps
module hub_cmd_decoder #(
  parameter int SAMPLE_BYTES = hub_cmd_pkg::ACCEL_SAMPLE_BYTES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [hub_cmd_pkg::NUM_SENSORS-1:0] sensor_present,
  input wire logic cmd_valid,
  input wire hub_cmd_pkg::cmd_byte_t cmd,
  output logic cmd_ready,
  output logic rsp_valid,
  output hub_cmd_pkg::rsp_byte_t rsp,
  input wire logic rsp_ready,
  output logic fifo_valid,
  output logic [7:0] fifo_data,
  output logic fifo_sample_end,
  input wire logic fifo_ready,
  output logic sns_valid,
  output hub_cmd_pkg::sns_req_t sns_req,
  input wire logic sns_done,
  input wire logic [7:0] sns_rdata,
  input wire logic [7:0] attr_word_bytes,
  input wire logic [7:0] attr_reg_count
);

  typedef enum logic [2:0] {
    ST_FAMILY = 3'b000,
    ST_INDEX = 3'b001,
    ST_ARGS = 3'b010,
    ST_ACCESS = 3'b011,
    ST_ANSWER = 3'b100,
    ST_DRAIN = 3'b101
  } state_t;

  // ****************************************
  // Command parsing
  // ****************************************
  state_t state;
  logic [7:0] family;
  logic [2:0] sensor;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic arg_cnt;
  logic [7:0] dump_addr;
  logic [7:0] dump_last;
  logic [1:0] ans_step;
  logic [7:0] status;
  logic [7:0] read_val;
  logic [7:0] samp_cnt;
  logic dump_wait;
  logic buf_in_ready;
  logic fifo_push;
  logic byte_take;

  function automatic logic sensor_ok(input logic [7:0] idx, input logic [hub_cmd_pkg::NUM_SENSORS-1:0] pres);
    sensor_ok = (idx <= hub_cmd_pkg::IDX_ACCEL) && pres[idx[2:0]];
  endfunction

  // Input FIFO bytes stall the command stream while the buffer is full
  assign fifo_push = (state == ST_ARGS) && (family == hub_cmd_pkg::FAM_WRITE_IN_FIFO) && cmd_valid;
  assign byte_take = cmd_valid && cmd_ready;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmd_ready <= 1'b0;
    end else begin
      cmd_ready <= (state == ST_FAMILY) || (state == ST_INDEX) || (state == ST_DRAIN) ||
                   ((state == ST_ARGS) && ((family != hub_cmd_pkg::FAM_WRITE_IN_FIFO) || buf_in_ready));
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= ST_FAMILY;
      family <= 8'h00;
      sensor <= 3'h0;
      addr <= 8'h00;
      wdata <= 8'h00;
      arg_cnt <= 1'b0;
      status <= hub_cmd_pkg::STAT_OK;
      dump_addr <= 8'h00;
      dump_last <= 8'h00;
      ans_step <= 2'h0;
      read_val <= 8'h00;
      dump_wait <= 1'b0;
      sns_valid <= 1'b0;
      sns_req <= '0;
    end else begin
      sns_valid <= 1'b0;
      unique case (state)
        ST_FAMILY: begin
          if (byte_take) begin
            family <= cmd.data;
            arg_cnt <= 1'b0;
            ans_step <= 2'h0;
            status <= cmd.last ? hub_cmd_pkg::STAT_BAD_CMD : hub_cmd_pkg::STAT_OK;
            state <= cmd.last ? ST_ANSWER : ST_INDEX;
          end
        end
        ST_INDEX: begin
          if (byte_take) begin
            sensor <= cmd.data[2:0];
            if (family == hub_cmd_pkg::FAM_WRITE_IN_FIFO) begin
              if (cmd.data != hub_cmd_pkg::IDX_IN_FIFO || !sensor_present[hub_cmd_pkg::IDX_ACCEL[2:0]]) begin
                status <= hub_cmd_pkg::STAT_BAD_SENSOR;
                state <= cmd.last ? ST_ANSWER : ST_DRAIN;
              end else begin
                state <= cmd.last ? ST_FAMILY : ST_ARGS;
              end
            end else if (family < hub_cmd_pkg::FAM_WRITE_REG || family > hub_cmd_pkg::FAM_DUMP_REGS) begin
              status <= hub_cmd_pkg::STAT_BAD_CMD;
              state <= cmd.last ? ST_ANSWER : ST_DRAIN;
            end else if (!sensor_ok(cmd.data, sensor_present)) begin
              status <= hub_cmd_pkg::STAT_BAD_SENSOR;
              state <= cmd.last ? ST_ANSWER : ST_DRAIN;
            end else if (family == hub_cmd_pkg::FAM_GET_ATTR || family == hub_cmd_pkg::FAM_DUMP_REGS) begin
              state <= cmd.last ? ST_ANSWER : ST_DRAIN;
              dump_addr <= 8'h00;
              dump_last <= attr_reg_count - 8'h01;
              status <= cmd.last ? hub_cmd_pkg::STAT_OK : hub_cmd_pkg::STAT_BAD_CMD;
            end else if (cmd.last) begin
              status <= hub_cmd_pkg::STAT_BAD_CMD;
              state <= ST_ANSWER;
            end else begin
              state <= ST_ARGS;
            end
          end
        end
        ST_ARGS: begin
          if (byte_take && family == hub_cmd_pkg::FAM_WRITE_IN_FIFO) begin
            if (cmd.last) begin
              state <= ST_FAMILY;
            end
          end else if (byte_take) begin
            if (!arg_cnt) begin
              addr <= cmd.data;
              arg_cnt <= 1'b1;
            end else begin
              wdata <= cmd.data;
            end
            if (cmd.last) begin
              if (family == hub_cmd_pkg::FAM_WRITE_REG && !arg_cnt) begin
                status <= hub_cmd_pkg::STAT_BAD_CMD;
                state <= ST_ANSWER;
              end else begin
                state <= ST_ACCESS;
                sns_valid <= 1'b1;
                sns_req.sensor <= sensor;
                sns_req.write <= (family == hub_cmd_pkg::FAM_WRITE_REG);
                sns_req.addr <= arg_cnt ? addr : cmd.data;
                sns_req.wdata <= cmd.data;
              end
            end
          end
        end
        ST_ACCESS: begin
          if (sns_done) begin
            read_val <= sns_rdata;
            state <= (family == hub_cmd_pkg::FAM_WRITE_REG) ? ST_FAMILY : ST_ANSWER;
          end
        end
        ST_DRAIN: begin
          if (byte_take && cmd.last) begin
            state <= ST_ANSWER;
          end
        end
        ST_ANSWER: begin
          if (rsp_valid && rsp_ready && rsp.last) begin
            state <= ST_FAMILY;
          end else if (rsp_valid && rsp_ready) begin
            ans_step <= ans_step + 2'h1;
            if (family == hub_cmd_pkg::FAM_DUMP_REGS && ans_step == 2'h3) begin
              ans_step <= 2'h1;
              dump_addr <= dump_addr + 8'h01;
            end
          end else if (family == hub_cmd_pkg::FAM_DUMP_REGS && ans_step == 2'h1) begin
            // One read per register; its done moves the dump on to the address byte
            if (!dump_wait) begin
              dump_wait <= 1'b1;
              sns_valid <= 1'b1;
              sns_req.sensor <= sensor;
              sns_req.write <= 1'b0;
              sns_req.addr <= dump_addr;
            end else if (sns_done) begin
              dump_wait <= 1'b0;
              read_val <= sns_rdata;
              ans_step <= 2'h2;
            end
          end
        end
        default: state <= ST_FAMILY;
      endcase
    end
  end

  // ****************************************
  // Answer stream: status byte then payload
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rsp_valid <= 1'b0;
      rsp <= '0;
    end else if (rsp_valid && !rsp_ready) begin
      rsp_valid <= 1'b1;
    end else if (state == ST_ANSWER && !(rsp_valid && rsp_ready)) begin
      rsp_valid <= 1'b0;
      if (ans_step == 2'h0) begin
        rsp_valid <= 1'b1;
        rsp.data <= status;
        rsp.last <= (status != hub_cmd_pkg::STAT_OK) || (family == hub_cmd_pkg::FAM_DUMP_REGS && dump_last == 8'hFF);
      end else if (family == hub_cmd_pkg::FAM_READ_REG) begin
        rsp_valid <= 1'b1;
        rsp.data <= read_val;
        rsp.last <= 1'b1;
      end else if (family == hub_cmd_pkg::FAM_GET_ATTR) begin
        rsp_valid <= 1'b1;
        rsp.data <= (ans_step == 2'h1) ? attr_word_bytes : attr_reg_count;
        rsp.last <= (ans_step == 2'h2);
      end else if (ans_step == 2'h2) begin
        rsp_valid <= 1'b1;
        rsp.data <= dump_addr;
        rsp.last <= 1'b0;
      end else if (ans_step == 2'h3) begin
        rsp_valid <= 1'b1;
        rsp.data <= read_val;
        rsp.last <= (dump_addr == dump_last);
      end
    end else begin
      rsp_valid <= 1'b0;
    end
  end

  // ****************************************
  // Two-entry skid buffer toward the input FIFO
  // ****************************************
  logic [1:0][8:0] buf_mem;
  logic [1:0] buf_cnt;
  logic buf_rd;
  logic buf_wr;
  logic buf_pop;
  logic [1:0] next_buf_cnt;
  assign buf_wr = fifo_push && cmd_ready;
  assign buf_rd = fifo_valid && fifo_ready;
  assign buf_pop = (buf_rd || !fifo_valid) && (buf_cnt != 2'h0);
  assign next_buf_cnt = buf_cnt + (buf_wr ? 2'h1 : 2'h0) - (buf_pop ? 2'h1 : 2'h0);
  // Ready is registered, so it must see the count after this cycle's write or a third byte would overrun
  assign buf_in_ready = (next_buf_cnt != 2'h2);

  // Sample boundaries marked so the FIFO can check whole samples
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      samp_cnt <= 8'h00;
    end else if (state == ST_INDEX) begin
      samp_cnt <= 8'h00;
    end else if (buf_wr) begin
      samp_cnt <= (samp_cnt == 8'(SAMPLE_BYTES - 1)) ? 8'h00 : samp_cnt + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      buf_cnt <= 2'h0;
      buf_mem <= '0;
      fifo_valid <= 1'b0;
      fifo_data <= 8'h00;
      fifo_sample_end <= 1'b0;
    end else begin
      if (buf_rd || !fifo_valid) begin
        if (buf_cnt != 2'h0) begin
          fifo_valid <= 1'b1;
          {fifo_sample_end, fifo_data} <= buf_mem[0];
          buf_mem[0] <= buf_mem[1];
        end else begin
          fifo_valid <= 1'b0;
        end
      end
      if (buf_wr) begin
        buf_mem[buf_cnt - ((buf_rd || !fifo_valid) && buf_cnt != 2'h0 ? 2'h1 : 2'h0)] <=
          {samp_cnt == 8'(SAMPLE_BYTES - 1), cmd.data};
      end
      buf_cnt <= next_buf_cnt;
    end
  end

endmodule // hub_cmd_decoder

// [hub_cmd_pkg.sv]
package hub_cmd_pkg;

  // ****************************************
  // Command codes
  // ****************************************
  localparam logic [7:0] FAM_WRITE_IN_FIFO = 8'h14;
  localparam logic [7:0] FAM_WRITE_REG = 8'h40;
  localparam logic [7:0] FAM_READ_REG = 8'h41;
  localparam logic [7:0] FAM_GET_ATTR = 8'h42;
  localparam logic [7:0] FAM_DUMP_REGS = 8'h43;
  localparam logic [7:0] IDX_IN_FIFO = 8'h00;
  localparam logic [7:0] IDX_ACCEL = 8'h04;
  localparam int NUM_SENSORS = 5;
  localparam int ACCEL_SAMPLE_BYTES = 6;

  // ****************************************
  // Status codes returned with each answer
  // ****************************************
  localparam logic [7:0] STAT_OK = 8'h00;
  localparam logic [7:0] STAT_BAD_CMD = 8'h01;
  localparam logic [7:0] STAT_BAD_SENSOR = 8'h02;

  // ****************************************
  // Sensor attributes after reset
  // ****************************************
  localparam logic [7:0] DEF_WORD_BYTES = 8'h01;
  localparam logic [7:0] DEF_REG_COUNT = 8'h10;
  localparam logic [NUM_SENSORS-1:0] DEF_SENSOR_PRESENT = 5'h1F;

  // One byte of a command stream from the I2C framer
  typedef struct packed {
    logic [7:0] data;
    logic first;
    logic last;
  } cmd_byte_t;

  // One byte of an answer stream toward the I2C framer
  typedef struct packed {
    logic [7:0] data;
    logic last;
  } rsp_byte_t;

  // Register access issued toward a sensor
  typedef struct packed {
    logic [2:0] sensor;
    logic write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sns_req_t;

endpackage

// [hub_cmd_assertions.sv]
`timescale 1ns/10ps
// ****
// Port checker
// ****
module hub_cmd_checker #(
  parameter int SAMPLE_BYTES = hub_cmd_pkg::ACCEL_SAMPLE_BYTES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [hub_cmd_pkg::NUM_SENSORS-1:0] sensor_present,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire hub_cmd_pkg::rsp_byte_t rsp,
  input wire logic rsp_ready,
  input wire logic fifo_valid,
  input wire logic [7:0] fifo_data,
  input wire logic fifo_sample_end,
  input wire logic fifo_ready,
  input wire logic sns_valid,
  input wire hub_cmd_pkg::sns_req_t sns_req,
  input wire logic sns_done
);
  int cnt;
  logic pend;
  // Byte position inside the current sample
  always_ff @(posedge clk) begin
    if (!rst_n) cnt <= 0;
    else if (fifo_valid && fifo_ready) cnt <= (cnt == SAMPLE_BYTES - 1) ? 0 : cnt + 1;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) pend <= 1'b0;
    else if (sns_valid) pend <= 1'b1;
    else if (sns_done) pend <= 1'b0;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_rsp_hold;
    rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp);
  endproperty
  a_rsp_hold: assert property (p_rsp_hold) else $error("answer changed while stalled");
  property p_fifo_hold;
    fifo_valid && !fifo_ready |=> fifo_valid && $stable({fifo_data, fifo_sample_end});
  endproperty
  a_fifo_hold: assert property (p_fifo_hold) else $error("fifo byte changed while stalled");
  property p_sample_end;
    fifo_valid |-> fifo_sample_end == (cnt == SAMPLE_BYTES - 1);
  endproperty
  a_sample_end: assert property (p_sample_end) else $error("sample end misplaced");
  property p_sns_pulse;
    sns_valid |=> !sns_valid;
  endproperty
  a_sns_pulse: assert property (p_sns_pulse) else $error("sensor request longer than a cycle");
  property p_one_pending;
    sns_valid |-> !pend;
  endproperty
  a_one_pending: assert property (p_one_pending) else $error("request issued before done");
  property p_fitted;
    sns_valid |-> sns_req.sensor < 3'h5 && sensor_present[sns_req.sensor];
  endproperty
  a_fitted: assert property (p_fitted) else $error("request to absent sensor");
  property p_read_answer;
    sns_done && !sns_req.write |-> ##[0:3] rsp_valid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("no answer after read");
  property p_quiet;
    disable iff (1'b0) !rst_n |=> !rsp_valid && !fifo_valid && !sns_valid && !cmd_ready;
  endproperty
  a_quiet: assert property (p_quiet) else $error("output active after reset");
  c_last: cover property (rsp_valid && rsp_ready && rsp.last);
  c_end: cover property (fifo_valid && fifo_ready && fifo_sample_end);
  c_write: cover property (sns_valid && sns_req.write);
endmodule // hub_cmd_checker

bind hub_cmd_decoder hub_cmd_checker #(.SAMPLE_BYTES(SAMPLE_BYTES)) i_hub_cmd_checker (.clk(clk), .rst_n(rst_n),
  .sensor_present(sensor_present), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp(rsp),
  .rsp_ready(rsp_ready), .fifo_valid(fifo_valid), .fifo_data(fifo_data), .fifo_sample_end(fifo_sample_end),
  .fifo_ready(fifo_ready), .sns_valid(sns_valid), .sns_req(sns_req), .sns_done(sns_done));

// [sensor_bank_model.sv]
`timescale 1ns/10ps
// ****
// Sensor bank, latency 2 to 5 cycles
// ****
module sensor_bank_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sns_valid,
  input wire hub_cmd_pkg::sns_req_t sns_req,
  output logic sns_done,
  output logic [7:0] sns_rdata
);
  logic [7:0] mem [5][16];
  hub_cmd_pkg::sns_req_t held;
  logic busy;
  logic [1:0] dly;
  logic [1:0] nreq;
  initial begin
    sns_done = 1'b0;
    sns_rdata = 8'h00;
    for (int s = 0; s < 5; s++) begin
      for (int a = 0; a < 16; a++) mem[s][a] = 8'h5A ^ 8'(s * 16 + a);
    end
  end
  always @(posedge clk) begin
    sns_done <= 1'b0;
    // Data toggles outside done so a stale value is never mistaken for an answer
    sns_rdata <= ~sns_rdata;
    if (!rst_n) begin
      busy <= 1'b0;
      nreq <= 2'h0;
    end else if (busy && dly == 2'h0) begin
      busy <= 1'b0;
      sns_done <= 1'b1;
      if (held.write) mem[held.sensor][held.addr[3:0]] <= held.wdata;
      else sns_rdata <= mem[held.sensor][held.addr[3:0]];
    end else if (busy) begin
      dly <= dly - 2'h1;
    end else if (sns_valid) begin
      held <= sns_req;
      busy <= 1'b1;
      dly <= nreq;
      nreq <= nreq + 2'h1;
    end
  end
endmodule // sensor_bank_model

// [tb.sv]
`timescale 1ns/10ps
module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [hub_cmd_pkg::NUM_SENSORS-1:0] sensor_present = 5'h1F;
  logic cmd_valid = 1'b0;
  hub_cmd_pkg::cmd_byte_t cmd = '0;
  logic cmd_ready, rsp_valid, fifo_valid, fifo_sample_end, sns_valid, sns_done;
  logic rsp_ready = 1'b0;
  logic fifo_ready = 1'b0;
  hub_cmd_pkg::rsp_byte_t rsp;
  hub_cmd_pkg::sns_req_t sns_req;
  logic [7:0] fifo_data, sns_rdata;
  logic [7:0] attr_word_bytes = 8'h00;
  logic [7:0] attr_reg_count = 8'h00;
  int bad_count = 0;
  int num_checks = 0;
  logic [15:0] seed = 16'h34D2;
  logic [15:0] fseed = 16'h34D2;
  logic [8:0] fq [$];
  logic [7:0] fb [12];
  logic [7:0] shadow [5][16];

  always #5 clk = ~clk;

  hub_cmd_decoder i_hub_cmd_decoder (.clk(clk), .rst_n(rst_n), .sensor_present(sensor_present),
    .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp(rsp),
    .rsp_ready(rsp_ready), .fifo_valid(fifo_valid), .fifo_data(fifo_data), .fifo_sample_end(fifo_sample_end),
    .fifo_ready(fifo_ready), .sns_valid(sns_valid), .sns_req(sns_req), .sns_done(sns_done),
    .sns_rdata(sns_rdata), .attr_word_bytes(attr_word_bytes), .attr_reg_count(attr_reg_count));
  sensor_bank_model i_sensor_bank_model (.clk(clk), .rst_n(rst_n), .sns_valid(sns_valid), .sns_req(sns_req),
    .sns_done(sns_done), .sns_rdata(sns_rdata));

  // ****
  // Helpers
  // ****
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [7:0] rnd();
    seed = lfsr(seed);
    return seed[7:0];
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Valid stays up between bytes of one command
  task automatic send(input logic [7:0] d, input logic f, input logic l);
    int n = 0;
    cmd_valid = 1'b1;
    cmd = '{data: d, first: f, last: l};
    while (cmd_ready !== 1'b1 && n < 500) begin
      @(posedge clk);
      #1;
      n++;
    end
    @(posedge clk);
    #1;
    if (l) cmd_valid = 1'b0;
  endtask
  task automatic issue(input logic [7:0] fam, input logic [7:0] idx, input int na, input logic [7:0] a0,
                       input logic [7:0] a1);
    send(fam, 1'b1, 1'b0);
    send(idx, 1'b0, na == 0);
    if (na > 0) send(a0, 1'b0, na == 1);
    if (na > 1) send(a1, 1'b0, 1'b1);
  endtask
  task automatic get(input logic [7:0] d, input logic l);
    int n = 0;
    rsp_ready = rnd() > 8'h50;
    while (!(rsp_valid === 1'b1 && rsp_ready) && n < 500) begin
      @(posedge clk);
      #1;
      rsp_ready = rnd() > 8'h50;
      n++;
    end
    chk({rsp.data, 7'h00, rsp.last}, {d, 7'h00, l});
    @(posedge clk);
    #1;
  endtask
  task automatic quiet();
    rsp_ready = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk(16'(rsp_valid), 16'h0000);
  endtask

  always @(posedge clk) begin
    #1;
    fseed = lfsr(fseed);
    fifo_ready = fseed[0] | fseed[3];
  end
  always @(posedge clk) begin
    if (fifo_valid === 1'b1 && fifo_ready) fq.push_back({fifo_sample_end, fifo_data});
  end

  initial begin
    #300000;
    bad_count++;
    report_and_stop();
  end

  // ****
  // Scenarios
  // ****
  initial begin
    logic [7:0] a, v;
    for (int s = 0; s < 5; s++) begin
      for (int r = 0; r < 16; r++) shadow[s][r] = 8'h5A ^ 8'(s * 16 + r);
    end
    repeat (4) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    send(8'h14, 1'b1, 1'b0);
    send(8'h00, 1'b0, 1'b0);
    for (int i = 0; i < 12; i++) begin
      fb[i] = rnd();
      send(fb[i], 1'b0, i == 11);
    end
    for (int n = 0; n < 200 && fq.size() < 12; n++) @(posedge clk);
    #1;
    chk(16'(fq.size()), 16'h000C);
    for (int i = 0; i < 12; i++) chk(16'(fq[i]), 16'({i % 6 == 5, fb[i]}));
    quiet();
    for (int s = 0; s < 5; s++) begin
      a = rnd() & 8'h0F;
      v = rnd();
      shadow[s][a[3:0]] = v;
      issue(8'h40, 8'(s), 2, a, v);
      quiet();
      issue(8'h41, 8'(s), 1, a, 8'h00);
      get(hub_cmd_pkg::STAT_OK, 1'b0);
      get(v, 1'b1);
      attr_word_bytes = rnd();
      attr_reg_count = rnd();
      issue(8'h42, 8'(s), 0, 8'h00, 8'h00);
      get(hub_cmd_pkg::STAT_OK, 1'b0);
      get(attr_word_bytes, 1'b0);
      get(attr_reg_count, 1'b1);
    end
    attr_reg_count = 8'h03;
    issue(8'h43, 8'h04, 0, 8'h00, 8'h00);
    get(hub_cmd_pkg::STAT_OK, 1'b0);
    for (int r = 0; r < 3; r++) begin
      get(8'(r), 1'b0);
      get(shadow[4][r], r == 2);
    end
    sensor_present = 5'h17;
    issue(8'h41, 8'h03, 1, 8'h01, 8'h00);
    get(hub_cmd_pkg::STAT_BAD_SENSOR, 1'b1);
    issue(8'h40, 8'h03, 2, 8'h01, 8'hEE);
    get(hub_cmd_pkg::STAT_BAD_SENSOR, 1'b1);
    issue(8'h55, 8'h00, 0, 8'h00, 8'h00);
    get(hub_cmd_pkg::STAT_BAD_CMD, 1'b1);
    sensor_present = 5'h1F;
    issue(8'h41, 8'h03, 1, 8'h01, 8'h00);
    get(hub_cmd_pkg::STAT_OK, 1'b0);
    get(shadow[3][1], 1'b1);
    report_and_stop();
  end
endmodule // tb
